// *** hw/hbridge_pkg.sv ***
// constants shared by the dual h-bridge drive control block
// assumes a 125 MHz pclk and an apb register master
package hbridge_pkg;
   localparam int unsigned CLK_MHZ            = 125;
   localparam int unsigned CLK_KHZ            = 125000;
   // timing figures in their printed units
   localparam int unsigned BLANK_TIME_NS      = 3750;
   localparam int unsigned DEAD_TIME_NS       = 450;
   localparam int unsigned PWM_FREQ_KHZ       = 50;
   localparam int unsigned OCP_DEGLITCH_US    = 4;
   localparam int unsigned OCP_RETRY_US       = 1350;
   localparam int unsigned WAKE_TIME_US       = 1000;
   // cycle counts
   localparam int unsigned BLANK_CYC   = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DEAD_CYC    = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned PWM_CYC     = CLK_KHZ / PWM_FREQ_KHZ;
   localparam int unsigned DEG_CYC     = OCP_DEGLITCH_US * CLK_MHZ;
   localparam int unsigned RETRY_CYC   = OCP_RETRY_US * CLK_MHZ;
   localparam int unsigned WAKE_CYC    = WAKE_TIME_US * CLK_MHZ;
   localparam int unsigned WAKE_USE_CYC = WAKE_CYC / 2;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF    = 8'h00;
   localparam logic [7:0] STATUS_OFF  = 8'h04;
   localparam logic [7:0] PWMCNT_OFF  = 8'h08;
   // control register field positions and reset value
   localparam int unsigned CTRL_A1    = 0;
   localparam int unsigned CTRL_A2    = 1;
   localparam int unsigned CTRL_B1    = 2;
   localparam int unsigned CTRL_B2    = 3;
   localparam int unsigned CTRL_SRC   = 4;
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   // bridge leg encoding on the drive outputs
   typedef enum logic [1:0] {
      LEG_OFF  = 2'b00,
      LEG_LOW  = 2'b01,
      LEG_HIGH = 2'b10
   } leg_t;
   typedef enum logic [1:0] {
      BR_RUN   = 2'b00,
      BR_CHOP  = 2'b01,
      BR_OCP   = 2'b10
   } bridge_state_t;
endpackage : hbridge_pkg

// *** hw/hbridge_leg.sv ***
// one h-bridge: input decode, chopping, overcurrent retry, dead time
// assumes synchronised inputs and a shared pwm cycle start pulse
`timescale 1ns/1ps
module hbridge_leg (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       enable,
   input  wire logic       ctrl_1,
   input  wire logic       ctrl_2,
   input  wire logic       pwm_start,
   input  wire logic       sense_trip,
   input  wire logic [3:0] ilimit,
   output logic [1:0]      drive_1,
   output logic [1:0]      drive_2,
   output logic            ocp_active,
   output logic            chop_active
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   hbridge_pkg::bridge_state_t state;
   logic [31:0] deg_cnt;
   logic [31:0] retry_cnt;
   logic [15:0] blank_cnt;
   logic [1:0]  want_1;
   logic [1:0]  want_2;
   logic [1:0]  prev_1;
   logic [1:0]  prev_2;
   logic [7:0]  dead_1;
   logic [7:0]  dead_2;
   logic        chopped;
   logic        energised;

   // ------------------------------------------------------------
   // decoded target per leg
   // ------------------------------------------------------------
   always_comb begin
      want_1 = hbridge_pkg::LEG_OFF;
      want_2 = hbridge_pkg::LEG_OFF;
      if (!enable || state == hbridge_pkg::BR_OCP) begin
         want_1 = hbridge_pkg::LEG_OFF;                      // [R13] [R9]
         want_2 = hbridge_pkg::LEG_OFF;
      end else if (state == hbridge_pkg::BR_CHOP) begin
         want_1 = hbridge_pkg::LEG_LOW;                      // [R8] [R3]
         want_2 = hbridge_pkg::LEG_LOW;
      end else begin
         case ({ctrl_1, ctrl_2})                             // [R1] [R3]
            2'b01:   begin want_1 = hbridge_pkg::LEG_LOW;  want_2 = hbridge_pkg::LEG_HIGH; end
            2'b10:   begin want_1 = hbridge_pkg::LEG_HIGH; want_2 = hbridge_pkg::LEG_LOW;  end
            2'b11:   begin want_1 = hbridge_pkg::LEG_LOW;  want_2 = hbridge_pkg::LEG_LOW;  end
            default: begin want_1 = hbridge_pkg::LEG_OFF;  want_2 = hbridge_pkg::LEG_OFF;  end
         endcase
      end
   end

   assign energised = (drive_1 == hbridge_pkg::LEG_HIGH) || (drive_2 == hbridge_pkg::LEG_HIGH); // [R5]

   // ------------------------------------------------------------
   // blanking and chop control
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_cnt <= 16'h0000;
      end else if (!energised) begin
         blank_cnt <= 16'h0000;
      end else if (blank_cnt < 16'(hbridge_pkg::BLANK_CYC)) begin
         blank_cnt <= blank_cnt + 16'h0001;                  // [R5] [R6]
      end
   end

   // ------------------------------------------------------------
   // bridge state machine
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= hbridge_pkg::BR_RUN;
         deg_cnt   <= 32'h0000_0000;
         retry_cnt <= 32'h0000_0000;
         chopped   <= 1'b0;
      end else if (!enable) begin
         state     <= hbridge_pkg::BR_RUN;
         deg_cnt   <= 32'h0000_0000;
         retry_cnt <= 32'h0000_0000;
         chopped   <= 1'b0;
      end else begin
         if (state != hbridge_pkg::BR_OCP && |ilimit) begin
            deg_cnt <= deg_cnt + 32'h0000_0001;              // [R16]
         end else begin
            deg_cnt <= 32'h0000_0000;
         end
         if (pwm_start) begin
            chopped <= 1'b0;                                 // [R22]
         end
         case (state)
            hbridge_pkg::BR_RUN: begin
               if (deg_cnt >= hbridge_pkg::DEG_CYC) begin
                  state     <= hbridge_pkg::BR_OCP;          // [R13]
                  retry_cnt <= 32'h0000_0000;
               end else if (energised && sense_trip && !chopped && !pwm_start &&
                            blank_cnt >= 16'(hbridge_pkg::BLANK_CYC)) begin
                  state   <= hbridge_pkg::BR_CHOP;           // [R4] [R7] [R22]
                  chopped <= 1'b1;
               end
            end
            hbridge_pkg::BR_CHOP: begin
               if (deg_cnt >= hbridge_pkg::DEG_CYC) begin
                  state     <= hbridge_pkg::BR_OCP;
                  retry_cnt <= 32'h0000_0000;
               end else if (pwm_start) begin
                  state <= hbridge_pkg::BR_RUN;              // [R8] [R22]
               end
            end
            hbridge_pkg::BR_OCP: begin
               if (retry_cnt >= hbridge_pkg::RETRY_CYC - 1) begin
                  state <= hbridge_pkg::BR_RUN;              // [R14]
               end else begin
                  retry_cnt <= retry_cnt + 32'h0000_0001;
               end
            end
            default: state <= hbridge_pkg::BR_RUN;
         endcase
      end
   end

   // ------------------------------------------------------------
   // dead time: a leg that changes side passes through off first
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_1 <= hbridge_pkg::LEG_OFF;
         prev_1  <= hbridge_pkg::LEG_OFF;
         dead_1  <= 8'h00;
      end else if (want_1 == hbridge_pkg::LEG_OFF) begin
         drive_1 <= hbridge_pkg::LEG_OFF;
         prev_1  <= hbridge_pkg::LEG_OFF;
         dead_1  <= 8'h00;
      end else if (want_1 != prev_1) begin
         drive_1 <= hbridge_pkg::LEG_OFF;                    // [R20]
         if (dead_1 >= 8'(hbridge_pkg::DEAD_CYC - 1)) begin
            prev_1 <= want_1;
            dead_1 <= 8'h00;
         end else begin
            dead_1 <= dead_1 + 8'h01;
         end
      end else begin
         drive_1 <= want_1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_2 <= hbridge_pkg::LEG_OFF;
         prev_2  <= hbridge_pkg::LEG_OFF;
         dead_2  <= 8'h00;
      end else if (want_2 == hbridge_pkg::LEG_OFF) begin
         drive_2 <= hbridge_pkg::LEG_OFF;
         prev_2  <= hbridge_pkg::LEG_OFF;
         dead_2  <= 8'h00;
      end else if (want_2 != prev_2) begin
         drive_2 <= hbridge_pkg::LEG_OFF;                    // [R20]
         if (dead_2 >= 8'(hbridge_pkg::DEAD_CYC - 1)) begin
            prev_2 <= want_2;
            dead_2 <= 8'h00;
         end else begin
            dead_2 <= dead_2 + 8'h01;
         end
      end else begin
         drive_2 <= want_2;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ocp_active  <= 1'b0;
         chop_active <= 1'b0;
      end else begin
         ocp_active  <= (state == hbridge_pkg::BR_OCP);      // [R15]
         chop_active <= (state == hbridge_pkg::BR_CHOP);
      end
   end
endmodule : hbridge_leg

// *** hw/dual_hbridge_drive_control.sv ***
// top of the dual h-bridge drive control logic with apb status port
// assumes pins arrive asynchronously and the analog side supplies
// comparator, current limit, thermal and supply flags as levels
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Function
// R1 - per bridge: 00 coast, 01 reverse, 10 forward, 11 brake
// R2 - host pwms one input holding other low (fast) or high (slow)
// R3 - fast decay turns all switches off; slow decay shorts the winding
// R4 - sense trip stops drive until next fixed pwm cycle
// R5 - sense comparator ignored for 3.75 us after drive enables
// R6 - blanking interval is the minimum on-time while chopping
// R7 - chop from comparator tripping above 200 mV reference
// R8 - after chop both low sides on until next pwm cycle
// R9 - sleep low disables bridges, stops clocks, resets logic
// R10 - during sleep all other control inputs ignored
// R11 - bridges operate within 1 ms after sleep released
// R12 - host waits up to 1 ms after wake before trusting outputs
// R13 - current limit beyond deglitch time disables bridge, fault low
// R14 - bridge retries after retry period, repeating while fault lasts
// R15 - overcurrent shutdown affects only the bridge where detected
// R16 - high and low side overcurrent detected without sense path
// R17 - overtemperature disables switches, fault low, auto resume
// R18 - supply low lockout disables all and resets logic, no fault
// R19 - current control pwm cycle runs at 50 kHz
// R20 - about 450 ns dead time between opposite switches of a leg
// R21 - fault low while any overcurrent or thermal shutdown active
// R22 - at most one chop per pwm cycle; inputs restored each cycle
module dual_hbridge_drive_control #(
   parameter int unsigned WAKE_CYCLES = hbridge_pkg::WAKE_USE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        sleep_n,
   input  wire logic        supply_low_lockout,
   input  wire logic        thermal_shutdown,
   input  wire logic        bridge_a_ctrl_1,
   input  wire logic        bridge_a_ctrl_2,
   input  wire logic        bridge_b_ctrl_1,
   input  wire logic        bridge_b_ctrl_2,
   input  wire logic        sense_trip_a,
   input  wire logic        sense_trip_b,
   input  wire logic [3:0]  ilimit_a,
   input  wire logic [3:0]  ilimit_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [1:0]       bridge_a_drive_1,
   output logic [1:0]       bridge_a_drive_2,
   output logic [1:0]       bridge_b_drive_1,
   output logic [1:0]       bridge_b_drive_2,
   output logic             fault_n,
   output logic             fault_n_oe,
   output logic             awake
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int unsigned NSYNC = 17;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] pin_s1;
   logic [NSYNC-1:0] pin_s2;

   assign pin_raw = {sleep_n, supply_low_lockout, thermal_shutdown,
                     bridge_a_ctrl_1, bridge_a_ctrl_2, bridge_b_ctrl_1, bridge_b_ctrl_2,
                     sense_trip_a, sense_trip_b, ilimit_a, ilimit_b};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   logic       s_sleep_n;
   logic       s_supply_low_lockout;
   logic       s_tsd;
   logic [3:0] s_ctrl;
   logic       s_trip_a;
   logic       s_trip_b;
   logic [3:0] s_ilim_a;
   logic [3:0] s_ilim_b;

   assign s_sleep_n = pin_s2[16];
   assign s_supply_low_lockout    = pin_s2[15];
   assign s_tsd     = pin_s2[14];
   assign s_ctrl    = pin_s2[13:10];
   assign s_trip_a  = pin_s2[9];
   assign s_trip_b  = pin_s2[8];
   assign s_ilim_a  = pin_s2[7:4];
   assign s_ilim_b  = pin_s2[3:0];

   // ------------------------------------------------------------
   // sleep and lockout act as a logic reset
   // ------------------------------------------------------------
   logic hold_reset;
   assign hold_reset = !s_sleep_n || s_supply_low_lockout;                 // [R9] [R18]

   // ------------------------------------------------------------
   // wake timer
   // ------------------------------------------------------------
   logic [31:0] wake_cnt;
   logic        run;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt <= 32'h0000_0000;
         run      <= 1'b0;
      end else if (hold_reset) begin
         wake_cnt <= 32'h0000_0000;                          // [R9]
         run      <= 1'b0;
      end else if (!run) begin
         if (wake_cnt >= WAKE_CYCLES - 1) begin
            run <= 1'b1;                                     // [R11]
         end else begin
            wake_cnt <= wake_cnt + 32'h0000_0001;
         end
      end
   end

   // ------------------------------------------------------------
   // apb registers
   // ------------------------------------------------------------
   logic [31:0] ctrl;
   logic        apb_wr;
   logic        apb_rd;
   logic [15:0] pwm_cnt;
   logic        ocp_a;
   logic        ocp_b;
   logic        chop_a;
   logic        chop_b;

   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a == hbridge_pkg::CTRL_OFF) || (a == hbridge_pkg::STATUS_OFF) ||
                   (a == hbridge_pkg::PWMCNT_OFF);
   endfunction : known_addr

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= hbridge_pkg::CTRL_RST;
      end else if (apb_wr && paddr == hbridge_pkg::CTRL_OFF) begin
         ctrl <= {27'h0, pwdata[4:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !known_addr(paddr);
         if (apb_rd) begin
            case (paddr)
               hbridge_pkg::CTRL_OFF:   prdata <= ctrl;
               hbridge_pkg::STATUS_OFF: prdata <= {24'h0, s_supply_low_lockout, !s_sleep_n, run, s_tsd,
                                                   chop_b, chop_a, ocp_b, ocp_a};
               hbridge_pkg::PWMCNT_OFF: prdata <= {16'h0, pwm_cnt};
               default:                 prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // control source: pins, or register bits when selected
   // ------------------------------------------------------------
   logic [3:0] eff_ctrl;
   assign eff_ctrl = ctrl[hbridge_pkg::CTRL_SRC] ?
                     {ctrl[hbridge_pkg::CTRL_A1], ctrl[hbridge_pkg::CTRL_A2],
                      ctrl[hbridge_pkg::CTRL_B1], ctrl[hbridge_pkg::CTRL_B2]} : s_ctrl;

   // ------------------------------------------------------------
   // fixed frequency pwm cycle
   // ------------------------------------------------------------
   logic pwm_start;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_cnt   <= 16'h0000;
         pwm_start <= 1'b0;
      end else if (hold_reset) begin
         pwm_cnt   <= 16'h0000;                              // [R9]
         pwm_start <= 1'b0;
      end else if (pwm_cnt >= 16'(hbridge_pkg::PWM_CYC - 1)) begin
         pwm_cnt   <= 16'h0000;                              // [R19]
         pwm_start <= 1'b1;
      end else begin
         pwm_cnt   <= pwm_cnt + 16'h0001;
         pwm_start <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // bridges
   // ------------------------------------------------------------
   logic       bridge_en;
   logic [1:0] a_d1;
   logic [1:0] a_d2;
   logic [1:0] b_d1;
   logic [1:0] b_d2;

   assign bridge_en = run && !hold_reset && !s_tsd;          // [R10] [R17]

   hbridge_leg u_bridge_a (
      .pclk        (pclk),
      .presetn     (presetn),
      .enable      (bridge_en),
      .ctrl_1      (eff_ctrl[3]),
      .ctrl_2      (eff_ctrl[2]),
      .pwm_start   (pwm_start),
      .sense_trip  (s_trip_a),
      .ilimit      (s_ilim_a),
      .drive_1     (a_d1),
      .drive_2     (a_d2),
      .ocp_active  (ocp_a),
      .chop_active (chop_a)
   );

   hbridge_leg u_bridge_b (
      .pclk        (pclk),
      .presetn     (presetn),
      .enable      (bridge_en),
      .ctrl_1      (eff_ctrl[1]),
      .ctrl_2      (eff_ctrl[0]),
      .pwm_start   (pwm_start),
      .sense_trip  (s_trip_b),
      .ilimit      (s_ilim_b),
      .drive_1     (b_d1),
      .drive_2     (b_d2),
      .ocp_active  (ocp_b),
      .chop_active (chop_b)
   );

   // ------------------------------------------------------------
   // output registers and fault reporting
   // ------------------------------------------------------------
   logic fault_now;
   assign fault_now = !hold_reset && (ocp_a || ocp_b || s_tsd);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_a_drive_1 <= hbridge_pkg::LEG_OFF;
         bridge_a_drive_2 <= hbridge_pkg::LEG_OFF;
         bridge_b_drive_1 <= hbridge_pkg::LEG_OFF;
         bridge_b_drive_2 <= hbridge_pkg::LEG_OFF;
         fault_n          <= 1'b1;
         fault_n_oe       <= 1'b0;
         awake            <= 1'b0;
      end else begin
         bridge_a_drive_1 <= a_d1;
         bridge_a_drive_2 <= a_d2;
         bridge_b_drive_1 <= b_d1;
         bridge_b_drive_2 <= b_d2;
         fault_n          <= 1'b0;
         fault_n_oe       <= fault_now;                      // [R21] [R13] [R17] [R18]
         awake            <= run;
      end
   end
endmodule : dual_hbridge_drive_control

// *** dv/hbridge_asserts.sv ***
// checker for the dual h-bridge drive control top ports
// assumes one pclk domain with async active low presetn
`timescale 1ns/1ps
module hbridge_asserts #(
   parameter int unsigned WAKE_CYCLES = 20
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       sleep_n,
   input wire logic       supply_low_lockout,
   input wire logic       thermal_shutdown,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic [1:0] bridge_a_drive_1,
   input wire logic [1:0] bridge_a_drive_2,
   input wire logic [1:0] bridge_b_drive_1,
   input wire logic [1:0] bridge_b_drive_2,
   input wire logic       fault_n,
   input wire logic       fault_n_oe,
   input wire logic       awake
);
   localparam int WAKE_MAX = WAKE_CYCLES + 8;
   logic off;
   assign off = {bridge_a_drive_1, bridge_a_drive_2, bridge_b_drive_1, bridge_b_drive_2} == 8'h00;
   function automatic logic jump(input logic [1:0] p, input logic [1:0] c);
      return (p ^ c) == 2'h3;
   endfunction : jump
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_sleep; !sleep_n [*5]; endsequence
   sequence s_low; supply_low_lockout [*5]; endsequence
   sequence s_hot; (thermal_shutdown && sleep_n && !supply_low_lockout) [*5]; endsequence
   a_sleep_off: assert property (s_sleep |-> off) else $error("drive in sleep");
   a_sleep_nofault: assert property (s_sleep |-> !fault_n_oe) else $error("fault in sleep");
   a_lockout_off: assert property (s_low |-> off && !fault_n_oe) else $error("lockout drive");
   a_hot_off: assert property (s_hot |-> off && fault_n_oe) else $error("thermal not off");
   a_fault_drain: assert property (fault_n_oe |-> !fault_n) else $error("fault line high");
   a_dead_a: assert property (!jump($past(bridge_a_drive_1), bridge_a_drive_1)
      && !jump($past(bridge_a_drive_2), bridge_a_drive_2)) else $error("no dead time a");
   a_dead_b: assert property (!jump($past(bridge_b_drive_1), bridge_b_drive_1)
      && !jump($past(bridge_b_drive_2), bridge_b_drive_2)) else $error("no dead time b");
   a_leg_legal: assert property ({bridge_a_drive_1, bridge_a_drive_2} != 4'hA
      && {bridge_b_drive_1, bridge_b_drive_2} != 4'hA) else $error("bad leg code");
   a_wake_bound: assert property ($rose(sleep_n) |-> ##[1:WAKE_MAX]
      (awake || !sleep_n || supply_low_lockout)) else $error("wake too slow");
   a_asleep_idle: assert property (!awake [*2] |-> off) else $error("drive before wake");
   a_apb_ready: assert property (psel && !penable |=> pready) else $error("apb no ready");
endmodule : hbridge_asserts
bind dual_hbridge_drive_control hbridge_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) u_hbridge_asserts (.pclk,
   .presetn, .sleep_n, .supply_low_lockout, .thermal_shutdown, .psel, .penable, .pready, .bridge_a_drive_1,
   .bridge_a_drive_2, .bridge_b_drive_1, .bridge_b_drive_2, .fault_n, .fault_n_oe, .awake);

// *** dv/host_pins.sv ***
// host pin model: drives the control pin pairs of both bridges
// assumes the bench sets commands just after a clock edge
`timescale 1ns/1ps
module host_pins (
   input  wire logic       pclk,
   input  wire logic [1:0] cmd_a,
   input  wire logic [1:0] cmd_b,
   output logic            bridge_a_ctrl_1,
   output logic            bridge_a_ctrl_2,
   output logic            bridge_b_ctrl_1,
   output logic            bridge_b_ctrl_2
);
   initial {bridge_a_ctrl_1, bridge_a_ctrl_2, bridge_b_ctrl_1, bridge_b_ctrl_2} = 4'h0;
   // pin pairs move together; the steady pin is held while the other changes
   always @(posedge pclk) begin
      {bridge_a_ctrl_1, bridge_a_ctrl_2} <= cmd_a;
      {bridge_b_ctrl_1, bridge_b_ctrl_2} <= cmd_b;
   end
endmodule : host_pins

// *** dv/test_dual_hbridge_drive_control.sv ***
// self-checking bench for the dual h-bridge drive control block
// assumes hbridge_pkg, host_pins and the checker are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("Error %0t: got %h exp %h", $time, g, e); end end
`define WAITC(c, l) n = 0; while (!(c) && n < l) begin @(posedge pclk); n++; end
module test_dual_hbridge_drive_control;
   localparam int unsigned WAKE = 20;
   logic        pclk, presetn, sleep_n, supply_low_lockout, thermal_shutdown, er;
   logic        sense_trip_a, sense_trip_b, psel, penable, pwrite, pready, pslverr, fault_n, fault_n_oe, awake;
   logic        bridge_a_ctrl_1, bridge_a_ctrl_2, bridge_b_ctrl_1, bridge_b_ctrl_2;
   logic [1:0]  cmd_a, cmd_b, bridge_a_drive_1, bridge_a_drive_2, bridge_b_drive_1, bridge_b_drive_2;
   logic [3:0]  ilimit_a, ilimit_b;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_errors, compares, n;
   dual_hbridge_drive_control #(.WAKE_CYCLES(WAKE)) u_dual_hbridge_drive_control (.pclk, .presetn, .sleep_n,
      .supply_low_lockout, .thermal_shutdown, .bridge_a_ctrl_1, .bridge_a_ctrl_2, .bridge_b_ctrl_1,
      .bridge_b_ctrl_2, .sense_trip_a, .sense_trip_b, .ilimit_a, .ilimit_b, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .bridge_a_drive_1, .bridge_a_drive_2, .bridge_b_drive_1,
      .bridge_b_drive_2, .fault_n, .fault_n_oe, .awake);
   host_pins u_host_pins (.pclk, .cmd_a, .cmd_b, .bridge_a_ctrl_1, .bridge_a_ctrl_2, .bridge_b_ctrl_1,
      .bridge_b_ctrl_2);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task cyc(input int k); repeat (k) @(posedge pclk); endtask : cyc
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata; er = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask : apb
   task chk_drv(input logic [7:0] e);
      `CHK({bridge_a_drive_1, bridge_a_drive_2, bridge_b_drive_1, bridge_b_drive_2}, e)
   endtask : chk_drv
   function automatic logic [3:0] dec(input logic [1:0] c);
      return {c == 2'h2 ? 2'h2 : (c == 2'h0 ? 2'h0 : 2'h1), c == 2'h1 ? 2'h2 : (c == 2'h0 ? 2'h0 : 2'h1)};
   endfunction : dec
   task wake();
      `WAITC(awake === 1'h1, WAKE + 50)
      `CHK(n <= WAKE + 10, 1'h1)
      cyc(70); // host waits before trusting outputs
   endtask : wake
   task end_of_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_decode();
      for (int c = 0; c < 16; c++) begin
         cmd_a <= c[3:2]; cmd_b <= c[1:0]; cyc(70);
         chk_drv({dec(c[3:2]), dec(c[1:0])});
      end
   endtask : t_decode
   task t_apb();
      apb(1'h0, hbridge_pkg::CTRL_OFF, 32'h0); `CHK(rd, hbridge_pkg::CTRL_RST)
      apb(1'h1, hbridge_pkg::CTRL_OFF, 32'hFFFF_FFF6); apb(1'h0, hbridge_pkg::CTRL_OFF, 32'h0);
      `CHK(rd, 32'h0000_0016) cyc(70); chk_drv(8'h69);
      apb(1'h1, hbridge_pkg::CTRL_OFF, 32'h0); apb(1'h0, 8'h0C, 32'h0); `CHK({er, rd}, 33'h1_0000_0000)
   endtask : t_apb
   task t_chop();
      cmd_a <= 2'h2; cmd_b <= 2'h0; cyc(70); sense_trip_a <= 1'h1;
      `WAITC(bridge_a_drive_1 === 2'h1, 3000)
      `WAITC(bridge_a_drive_1 === 2'h2, 2700)
      `CHK(n < 2700, 1'h1)
      `WAITC(bridge_a_drive_1 !== 2'h2, 3000)
      `CHK(n >= hbridge_pkg::BLANK_CYC && n < hbridge_pkg::BLANK_CYC + 60, 1'h1)
      cyc(60); chk_drv(8'h50);
      sense_trip_a <= 1'h0;
   endtask : t_chop
   task t_ocp();
      cmd_b <= 2'h2; ilimit_a <= 4'h1; cyc(100); ilimit_a <= 4'h0; cyc(20);
      `CHK(fault_n_oe, 1'h0)
      ilimit_a <= 4'h8; cyc(hbridge_pkg::DEG_CYC + 20); ilimit_a <= 4'h0; cyc(5);
      chk_drv(8'h09);
      `CHK({fault_n_oe, fault_n}, 2'h2)
      apb(1'h0, hbridge_pkg::STATUS_OFF, 32'h0); `CHK(rd[1:0], 2'h1)
      cyc(200); `CHK(fault_n_oe, 1'h1)
   endtask : t_ocp
   task t_sleep();
      sleep_n <= 1'h0; cyc(10); chk_drv(8'h00);
      `CHK(fault_n_oe, 1'h0)
      cmd_a <= 2'h3; cmd_b <= 2'h1; cyc(10); chk_drv(8'h00);
      sleep_n <= 1'h1; wake(); chk_drv(8'h56);
   endtask : t_sleep
   task t_faults();
      thermal_shutdown <= 1'h1; cyc(10); chk_drv(8'h00);
      `CHK(fault_n_oe, 1'h1)
      thermal_shutdown <= 1'h0; cyc(70); `CHK(fault_n_oe, 1'h0)
      chk_drv(8'h56);
      supply_low_lockout <= 1'h1; cyc(10); chk_drv(8'h00);
      `CHK(fault_n_oe, 1'h0)
      supply_low_lockout <= 1'h0; wake(); chk_drv(8'h56);
   endtask : t_faults
   // ----------------------------------------
   // run
   // ----------------------------------------
   initial begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      presetn = 1'h0; sleep_n = 1'h1; supply_low_lockout = 1'h0; thermal_shutdown = 1'h0;
      sense_trip_a = 1'h0; sense_trip_b = 1'h0; ilimit_a = 4'h0; ilimit_b = 4'h0; cmd_a = 2'h0; cmd_b = 2'h0;
      psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00; pwdata = 32'h0; n_errors = 0; compares = 0;
      cyc(2); presetn <= 1'h1;
      wake(); t_decode(); t_apb(); t_chop(); t_ocp(); t_sleep(); t_faults();
      end_of_test();
   end
   initial begin
      cyc(30000); n_errors++;
      end_of_test();
   end
endmodule : test_dual_hbridge_drive_control
